// ---- mrs_defines.svh ----
// constants for the serial register-access slave front end
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH
`define MRS_ID_RESET 8'h01
`define MRS_ID_BCAST 8'h00
`define MRS_ID_MAX 8'hF7
`define MRS_FC_READ 8'h03
`define MRS_FC_WR1 8'h06
`define MRS_FC_WRN 8'h10
`define MRS_EXC_BIT 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VAL 8'h03
`define MRS_RD_MAX 16'h007D
`define MRS_WR_MAX 16'h007B
`define MRS_GAP_LAST 2'h2
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`define MRS_POS_ID 8'h00
`define MRS_POS_FC 8'h01
`define MRS_POS_HDR 8'h02
`define MRS_POS_RDATA 8'h03
`define MRS_POS_WR1 8'h04
`define MRS_POS_BCNT 8'h06
`define MRS_POS_WDATA 8'h07
`define MRS_LEN_MIN 9'h004
`define MRS_LEN_SHORT 9'h008
`define MRS_LEN_WRN 9'h009
`define MRS_LEN_ECHO 9'h006
`define MRS_LEN_HDR3 9'h003
`define MRS_MEM_DEPTH 256
`define MRS_CLK_NS 100
`define MRS_T_CMD_NS 2500000
`define MRS_T_CFG_NS 8000000
`endif

// ---- mrs_pkg.sv ----
// types shared by the front end
package mrs_pkg;
  typedef enum logic [8:0] {
    ST_RECV = 9'h001,
    ST_CHECK = 9'h002,
    ST_REQ = 9'h004,
    ST_WAIT = 9'h008,
    ST_STORE = 9'h010,
    ST_EXC = 9'h020,
    ST_HDR = 9'h040,
    ST_SEND = 9'h080,
    ST_CRC = 9'h100
  } mrs_state_t;
endpackage : mrs_pkg

// ---- mrs_crc16.sv ----
// byte-wide check-value accumulator
`timescale 1ns/1ps
`include "mrs_defines.svh"
module mrs_crc16 (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic upd,
  input wire logic [7:0] data,
  output logic [15:0] crc
);
  function automatic logic [15:0] mrs_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int b = 0; b < 8; b++)
    begin
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1); // see R9
    end
    return r;
  endfunction : mrs_step

  // clear and upd together start a new message with this byte
  always_ff @(posedge clk)
  begin
    if (rst)
      crc <= `MRS_CRC_INIT;
    else if (upd)
      crc <= mrs_step(clear ? `MRS_CRC_INIT : crc, data); // see R9
    else if (clear)
      crc <= `MRS_CRC_INIT;
  end
endmodule : mrs_crc16

// ---- mrs_fifo.sv ----
// reply byte buffer with registered output stage
`timescale 1ns/1ps
module mrs_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(D));
  assign push = in_valid && in_ready;
  assign pop = (cnt_reg != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_reg] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (pop)
        rp_reg <= rp_reg + 1'b1;
      if (push && !pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop && !push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rp_reg];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule : mrs_fifo

// ---- mrs_frontend.sv ----
// serial register-access slave: framing, checks, execution, replies
// Operation
// R1: reply starts within 2.5 ms, config 8 ms
// R2: own identifier resets to 1, user-writable
// R3: function zero and 128-255 never valid requests
// R4: normal reply echoes code, exception sets bit7
// R5: frame is id, function, data, check value
// R6: three idle characters end/flush the frame
// R7: identifier zero executes, never replies
// R8: multi-byte fields sent high byte first
// R9: check value preset ones, shift right, A001
// R10: check value low byte first, then high
// R11: parity or check errors dropped silently
// R12: master times out unanswered requests itself
// R13: exception frame: id, marked code, code, check
// R14: codes 01 function, 02 address, 03 value
// R15: serve only functions 3, 6, 16
// R16: frame addresses are zero-based, passed unchanged
// R17: read: address, count in; byte count, words out
// R18: device only answers requests to it
// R19: single write then exact echo reply
// R20: multi write 1-123 registers, short reply
// R21: zero count or bad byte count: value error
`timescale 1ns/1ps
`include "mrs_defines.svh"
module mrs_frontend #(
  parameter int CMD_LIMIT_CYCLES = `MRS_T_CMD_NS / `MRS_CLK_NS,
  parameter int CFG_LIMIT_CYCLES = `MRS_T_CFG_NS / `MRS_CLK_NS
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  input wire logic CHAR_TICK,
  input wire logic [7:0] ID_WDATA,
  input wire logic ID_WR,
  output logic [7:0] SLAVE_ID,
  output logic [15:0] REG_ADDR,
  output logic [15:0] REG_WDATA,
  output logic REG_RD,
  output logic REG_WR,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_ACK,
  input wire logic REG_ERR,
  input wire logic REG_CFG,
  output logic [7:0] TX_DATA,
  output logic TX_VALID,
  input wire logic TX_READY,
  output logic RESP_LATE
);
  logic [7:0] frame_mem [0:`MRS_MEM_DEPTH-1];
  mrs_pkg::mrs_state_t state_reg;
  logic [8:0] rx_len_reg, tx_len_reg, tx_idx_reg;
  logic rx_bad_reg, bcast_reg, crc_hi_reg, cfg_reg, timing_reg;
  logic [1:0] gap_reg;
  logic [7:0] fc_reg, hdr_reg, count_reg, idx_reg, rdata_lo_reg;
  logic [15:0] start_reg, rx_crc, tx_crc;
  logic [16:0] timer_reg;
  logic rx_take, frame_end, frame_ok, last_reg;
  logic [7:0] chk_code, rpos, wpos, fc_in, bcnt_in;
  logic [15:0] addr_in, cnt_in;
  logic mem_we;
  logic [7:0] mem_wa, mem_wd;
  logic fifo_in_valid, fifo_in_ready;
  logic [7:0] fifo_in_data;

  // bytes arriving while a request is being served are dropped
  assign rx_take = RX_VALID && (state_reg == mrs_pkg::ST_RECV);
  assign frame_end = (state_reg == mrs_pkg::ST_RECV) && CHAR_TICK
    && !RX_VALID && (gap_reg == `MRS_GAP_LAST) && (rx_len_reg != '0);
  assign fc_in = frame_mem[`MRS_POS_FC];
  assign addr_in = {frame_mem[`MRS_POS_HDR], frame_mem[`MRS_POS_RDATA]};
  assign cnt_in = {frame_mem[`MRS_POS_WR1], frame_mem[`MRS_POS_WR1 + 8'h01]};
  assign bcnt_in = frame_mem[`MRS_POS_BCNT];
  // a good frame's check value run over itself leaves zero
  assign frame_ok = !rx_bad_reg && (rx_len_reg >= `MRS_LEN_MIN)
    && (rx_crc == 16'h0000)
    && ((frame_mem[`MRS_POS_ID] == SLAVE_ID)
    || (frame_mem[`MRS_POS_ID] == `MRS_ID_BCAST)); // see R11 see R18
  assign last_reg = (idx_reg + 8'h01) == count_reg;
  assign rpos = `MRS_POS_RDATA + {idx_reg[6:0], 1'b0};
  assign wpos = `MRS_POS_WDATA + {idx_reg[6:0], 1'b0};

  // request validation, only meaningful in ST_CHECK
  always_comb
  begin
    chk_code = 8'h00;
    if (fc_in == `MRS_FC_READ) // see R15
    begin
      if (rx_len_reg != `MRS_LEN_SHORT || cnt_in == 16'h0000
          || cnt_in > `MRS_RD_MAX)
        chk_code = `MRS_EXC_VAL; // see R17 see R21
    end
    else if (fc_in == `MRS_FC_WR1)
    begin
      if (rx_len_reg != `MRS_LEN_SHORT)
        chk_code = `MRS_EXC_VAL;
    end
    else if (fc_in == `MRS_FC_WRN)
    begin
      if (cnt_in == 16'h0000 || cnt_in > `MRS_WR_MAX
          || {cnt_in[14:0], 1'b0} != {8'h00, bcnt_in}
          || rx_len_reg != `MRS_LEN_WRN + {1'b0, bcnt_in})
        chk_code = `MRS_EXC_VAL; // see R20 see R21
    end
    else
      chk_code = `MRS_EXC_FUNC; // see R3 see R14 see R15
  end

  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = rx_len_reg[7:0];
    mem_wd = RX_DATA;
    if (rx_take && !rx_len_reg[8])
      mem_we = 1'b1;
    else if (state_reg == mrs_pkg::ST_WAIT && REG_ACK && !REG_ERR
             && fc_reg == `MRS_FC_READ)
    begin
      mem_we = 1'b1;
      mem_wa = rpos;
      mem_wd = REG_RDATA[15:8]; // see R8 see R17
    end
    else if (state_reg == mrs_pkg::ST_STORE)
    begin
      mem_we = 1'b1;
      mem_wa = rpos + 8'h01;
      mem_wd = rdata_lo_reg;
    end
    else if (state_reg == mrs_pkg::ST_EXC)
    begin
      mem_we = 1'b1;
      mem_wa = `MRS_POS_FC;
      mem_wd = fc_reg | `MRS_EXC_BIT; // see R4 see R13
    end
    else if (state_reg == mrs_pkg::ST_HDR)
    begin
      mem_we = 1'b1;
      mem_wa = `MRS_POS_HDR;
      mem_wd = hdr_reg;
    end
  end

  // one buffer holds the request and is rewritten into the reply
  always_ff @(posedge CLOCK)
  begin
    if (mem_we)
      frame_mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
      SLAVE_ID <= `MRS_ID_RESET; // see R2
    else if (ID_WR && ID_WDATA != `MRS_ID_BCAST && ID_WDATA <= `MRS_ID_MAX)
      SLAVE_ID <= ID_WDATA; // see R2 see R7
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      rx_len_reg <= '0;
      rx_bad_reg <= 1'b0;
      gap_reg <= '0;
    end
    else if (state_reg == mrs_pkg::ST_CHECK)
    begin
      rx_len_reg <= '0;
      rx_bad_reg <= 1'b0;
    end
    else if (rx_take)
    begin
      gap_reg <= '0;
      if (rx_len_reg[8] || RX_ERR)
        rx_bad_reg <= 1'b1; // see R11
      if (!rx_len_reg[8])
        rx_len_reg <= rx_len_reg + 9'h001;
    end
    else if (CHAR_TICK && gap_reg != `MRS_GAP_LAST)
      gap_reg <= gap_reg + 2'h1; // see R6
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      state_reg <= mrs_pkg::ST_RECV;
      fc_reg <= '0;
      hdr_reg <= '0;
      count_reg <= '0;
      idx_reg <= '0;
      start_reg <= '0;
      rdata_lo_reg <= '0;
      bcast_reg <= 1'b0;
      cfg_reg <= 1'b0;
      crc_hi_reg <= 1'b0;
      tx_len_reg <= '0;
      tx_idx_reg <= '0;
    end
    else
    begin
      case (state_reg)
        mrs_pkg::ST_RECV:
          if (frame_end)
            state_reg <= mrs_pkg::ST_CHECK; // see R6
        mrs_pkg::ST_CHECK:
        begin
          fc_reg <= fc_in;
          bcast_reg <= frame_mem[`MRS_POS_ID] == `MRS_ID_BCAST; // see R7
          start_reg <= addr_in; // see R16
          count_reg <= (fc_in == `MRS_FC_WR1) ? 8'h01 : cnt_in[7:0];
          idx_reg <= '0;
          cfg_reg <= 1'b0;
          hdr_reg <= chk_code;
          if (!frame_ok)
            state_reg <= mrs_pkg::ST_RECV; // see R11
          else if (chk_code != 8'h00)
            state_reg <= mrs_pkg::ST_EXC; // see R13
          else
            state_reg <= mrs_pkg::ST_REQ;
        end
        mrs_pkg::ST_REQ:
          state_reg <= mrs_pkg::ST_WAIT;
        mrs_pkg::ST_WAIT:
          if (REG_ACK)
          begin
            cfg_reg <= cfg_reg | REG_CFG; // see R1
            rdata_lo_reg <= REG_RDATA[7:0];
            if (REG_ERR)
            begin
              hdr_reg <= `MRS_EXC_ADDR; // see R14
              state_reg <= mrs_pkg::ST_EXC;
            end
            else if (fc_reg == `MRS_FC_READ)
              state_reg <= mrs_pkg::ST_STORE;
            else if (!last_reg)
            begin
              idx_reg <= idx_reg + 8'h01;
              state_reg <= mrs_pkg::ST_REQ;
            end
            else
            begin
              tx_len_reg <= `MRS_LEN_ECHO; // see R19 see R20
              tx_idx_reg <= '0;
              state_reg <= bcast_reg ? mrs_pkg::ST_RECV : mrs_pkg::ST_SEND;
            end
          end
        mrs_pkg::ST_STORE:
          if (!last_reg)
          begin
            idx_reg <= idx_reg + 8'h01;
            state_reg <= mrs_pkg::ST_REQ;
          end
          else
          begin
            hdr_reg <= {count_reg[6:0], 1'b0}; // see R17
            tx_len_reg <= `MRS_LEN_HDR3 + {count_reg, 1'b0};
            state_reg <= mrs_pkg::ST_HDR;
          end
        mrs_pkg::ST_EXC:
        begin
          tx_len_reg <= `MRS_LEN_HDR3; // see R13
          state_reg <= mrs_pkg::ST_HDR;
        end
        mrs_pkg::ST_HDR:
        begin
          tx_idx_reg <= '0;
          state_reg <= bcast_reg ? mrs_pkg::ST_RECV : mrs_pkg::ST_SEND;
        end
        mrs_pkg::ST_SEND:
          if (fifo_in_ready)
          begin
            tx_idx_reg <= tx_idx_reg + 9'h001;
            crc_hi_reg <= 1'b0;
            if (tx_idx_reg + 9'h001 == tx_len_reg)
              state_reg <= mrs_pkg::ST_CRC;
          end
        mrs_pkg::ST_CRC:
          if (fifo_in_ready)
          begin
            crc_hi_reg <= 1'b1;
            if (crc_hi_reg)
              state_reg <= mrs_pkg::ST_RECV; // see R10
          end
        default:
          state_reg <= mrs_pkg::ST_RECV;
      endcase
    end
  end

  // strobes go out one cycle after ST_REQ, the first ST_WAIT cycle
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      REG_RD <= 1'b0;
      REG_WR <= 1'b0;
      REG_ADDR <= '0;
      REG_WDATA <= '0;
    end
    else
    begin
      REG_RD <= state_reg == mrs_pkg::ST_REQ && fc_reg == `MRS_FC_READ;
      REG_WR <= state_reg == mrs_pkg::ST_REQ && fc_reg != `MRS_FC_READ;
      if (state_reg == mrs_pkg::ST_REQ)
      begin
        REG_ADDR <= start_reg + {8'h00, idx_reg}; // see R16
        if (fc_reg == `MRS_FC_WR1)
          REG_WDATA <= cnt_in; // see R19
        else
          REG_WDATA <= {frame_mem[wpos], frame_mem[wpos + 8'h01]}; // see R8
      end
    end
  end

  // reply start deadline; a late start is flagged until the next frame
  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      timer_reg <= '0;
      timing_reg <= 1'b0;
      RESP_LATE <= 1'b0;
    end
    else if (frame_end)
    begin
      timer_reg <= '0;
      timing_reg <= 1'b1;
      RESP_LATE <= 1'b0;
    end
    else if (TX_VALID || state_reg == mrs_pkg::ST_RECV)
      timing_reg <= 1'b0;
    else if (timing_reg)
    begin
      timer_reg <= timer_reg + 17'h00001;
      // class is only known at an acknowledge, so the short limit is
      // judged once the accesses are done; a hung access waits for the long
      if (timer_reg == 17'(CFG_LIMIT_CYCLES - 1)
          || (!cfg_reg && timer_reg >= 17'(CMD_LIMIT_CYCLES - 1)
          && state_reg != mrs_pkg::ST_REQ && state_reg != mrs_pkg::ST_WAIT
          && state_reg != mrs_pkg::ST_STORE))
        RESP_LATE <= 1'b1; // see R1
    end
  end

  assign fifo_in_valid = (state_reg == mrs_pkg::ST_SEND)
    || (state_reg == mrs_pkg::ST_CRC);
  assign fifo_in_data = (state_reg == mrs_pkg::ST_SEND)
    ? frame_mem[tx_idx_reg[7:0]]
    : (crc_hi_reg ? tx_crc[15:8] : tx_crc[7:0]); // see R10

  mrs_crc16 u_rx_crc (
    .clk(CLOCK),
    .rst(SYS_RST),
    .clear(rx_len_reg == '0),
    .upd(rx_take),
    .data(RX_DATA),
    .crc(rx_crc)
  );

  mrs_crc16 u_tx_crc (
    .clk(CLOCK),
    .rst(SYS_RST),
    .clear(tx_idx_reg == '0),
    .upd(state_reg == mrs_pkg::ST_SEND && fifo_in_ready),
    .data(fifo_in_data),
    .crc(tx_crc)
  );

  mrs_fifo #(.W(8), .D(16)) u_tx_fifo (
    .clk(CLOCK),
    .rst(SYS_RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(TX_VALID),
    .out_ready(TX_READY),
    .out_data(TX_DATA)
  );

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_exc_tail;
    state_reg == mrs_pkg::ST_HDR ##1 (frame_mem[`MRS_POS_FC][7]
      && tx_len_reg == `MRS_LEN_HDR3);
  endsequence

  a_id_after_reset: assert property ( // see R2
    $fell(SYS_RST) |-> SLAVE_ID == `MRS_ID_RESET)
    else $error("identifier not 1 after reset");
  a_bcast_silent: assert property (bcast_reg |-> !fifo_in_valid) // see R7
    else $error("reply pushed for broadcast");
  a_bad_frame_drop: assert property ( // see R11
    (state_reg == mrs_pkg::ST_CHECK && !frame_ok)
      |=> state_reg == mrs_pkg::ST_RECV)
    else $error("bad frame not dropped");
  a_exc_marked: assert property ( // see R4
    state_reg == mrs_pkg::ST_EXC |=> s_exc_tail)
    else $error("exception reply not marked");
  a_unsup_func: assert property ( // see R15
    (state_reg == mrs_pkg::ST_CHECK && frame_ok && fc_in != `MRS_FC_READ
      && fc_in != `MRS_FC_WR1 && fc_in != `MRS_FC_WRN)
      |=> state_reg == mrs_pkg::ST_EXC && hdr_reg == `MRS_EXC_FUNC)
    else $error("unsupported function not refused");
  a_zero_count: assert property ( // see R21
    (state_reg == mrs_pkg::ST_CHECK && frame_ok && cnt_in == 16'h0000
      && fc_in != `MRS_FC_WR1 && chk_code != `MRS_EXC_FUNC)
      |=> hdr_reg == `MRS_EXC_VAL)
    else $error("zero count not refused");
  a_crc_low_first: assert property ( // see R10
    (state_reg == mrs_pkg::ST_CRC && !crc_hi_reg && fifo_in_ready)
      |-> fifo_in_data == tx_crc[7:0]
      ##1 (crc_hi_reg && fifo_in_data == tx_crc[15:8]))
    else $error("check value byte order wrong");
  a_gap_flush: assert property ( // see R6
    frame_end |=> state_reg == mrs_pkg::ST_CHECK ##1 rx_len_reg == '0)
    else $error("frame not closed at idle gap");
  a_late_flag: assert property ( // see R1
    (timing_reg && !frame_end && !TX_VALID && !cfg_reg
      && (state_reg == mrs_pkg::ST_HDR || state_reg == mrs_pkg::ST_SEND)
      && timer_reg >= 17'(CMD_LIMIT_CYCLES - 1)) |=> RESP_LATE)
    else $error("late reply not flagged");
endmodule : mrs_frontend

// ---- mrs_master_model.sv ----
// line-side host model: frames requests, gathers reply bytes
`timescale 1ns/1ps
module mrs_master_model (
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  output logic char_tick,
  output logic tx_ready,
  input wire logic clk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid
);
  logic [7:0] got[$];
  logic [2:0] phase = 3'h0;
  logic stall = 1'b0;
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_err = 1'b0;
  end
  // free-running character timer of the uart
  always @(posedge clk)
    phase <= phase + 3'h1;
  assign char_tick = (phase[1:0] == 2'h3);
  // one stall in eight keeps the reply buffer under pressure
  assign tx_ready = !stall && (phase != 3'h5);
  always @(posedge clk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i])
    begin
      c = c ^ {8'h00, f[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // id, function, data, then check value
  task automatic raw(input logic [7:0] f[$], input logic perr);
    got.delete();
    foreach (f[i])
    begin
      repeat (3) @(posedge clk);
      rx_data <= f[i];
      rx_valid <= 1'b1;
      rx_err <= perr && (i == 1);
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
      rx_data <= ~f[i]; // no stale byte between characters
    end
    repeat (16) @(posedge clk); // idle long enough to close the frame
  endtask : raw
  task automatic send(input logic [7:0] f[$], input logic bad,
                      input logic perr);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    raw(f, perr);
  endtask : send
endmodule : mrs_master_model

// ---- mrs_frontend_tb_top.sv ----
// self-checking bench for the serial slave front end
`timescale 1ns/1ps
module mrs_frontend_tb_top;
  typedef logic [7:0] mrs_bq_t[$];
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] rx_data, id_wdata = 8'h00, slave_id, tx_data;
  logic rx_valid, rx_err, char_tick, tx_valid, tx_ready, resp_late;
  logic id_wr = 1'b0, reg_rd, reg_wr, reg_ack = 1'b0;
  logic reg_err = 1'b0, reg_cfg = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata = 16'h0000;
  logic [15:0] wr_a[$], wr_d[$];
  int ack_dly = 2;
  int cnt = 0;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  mrs_frontend #(.CMD_LIMIT_CYCLES(50), .CFG_LIMIT_CYCLES(160)) dut_u (
    .CLOCK(clk), .SYS_RST(sys_rst), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_ERR(rx_err), .CHAR_TICK(char_tick),
    .ID_WDATA(id_wdata), .ID_WR(id_wr), .SLAVE_ID(slave_id),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RD(reg_rd),
    .REG_WR(reg_wr), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
    .REG_ERR(reg_err), .REG_CFG(reg_cfg), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .RESP_LATE(resp_late));
  mrs_master_model m (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_err(rx_err), .char_tick(char_tick), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // holding space: high addresses invalid, bit 14 marks configuration
  always @(posedge clk)
  begin
    if (reg_rd || reg_wr)
      cnt <= ack_dly;
    else if (cnt > 0)
      cnt <= cnt - 1;
    reg_ack <= (cnt == 1);
    reg_err <= (reg_addr >= 16'hF000);
    reg_cfg <= reg_addr[14];
    reg_rdata <= reg_addr ^ 16'h5A00;
    if (reg_wr)
    begin
      wr_a.push_back(reg_addr);
      wr_d.push_back(reg_wdata);
    end
  end
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  function automatic mrs_bq_t bq(input logic [95:0] v, input int n);
    mrs_bq_t q;
    for (int i = 0; i < n; i++)
      q.push_back(v[8*(n-1-i) +: 8]);
    return q;
  endfunction : bq
  task automatic xq(input mrs_bq_t r, input mrs_bq_t e, input logic bad,
                    input logic perr);
    logic [15:0] c;
    if (e.size() > 0)
    begin
      c = m.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    m.send(r, bad, perr);
    for (int k = 0; k < 600 && m.got.size() < e.size(); k++)
      @(negedge clk);
    repeat (60) @(negedge clk);
    check("reply length", 16'(m.got.size()), 16'(e.size()));
    foreach (e[i])
      if (i < m.got.size())
        check("reply byte", {8'h00, m.got[i]}, {8'h00, e[i]});
  endtask : xq
  task automatic xact(input logic [95:0] req, input int rn,
                      input logic [95:0] rsp, input int sn,
                      input logic bad = 1'b0, input logic perr = 1'b0);
    xq(bq(req, rn), bq(rsp, sn), bad, perr);
  endtask : xact
  task automatic t_normal();
    check("slave id", {8'h00, slave_id}, 16'h0001);
    xact(96'h010300100002, 6, 96'h0103045A105A11, 7);
    check("read addr", reg_addr, 16'h0011);
    xact(96'h010600201234, 6, 96'h010600201234, 6);
    check("wr1 addr", wr_a[$], 16'h0020);
    check("wr1 data", wr_d[$], 16'h1234);
    xact(96'h01100030000204AABBCCDD, 11, 96'h011000300002, 6);
    check("wrn addr", wr_a[$], 16'h0031);
    check("wrn data", wr_d[$], 16'hCCDD);
  endtask : t_normal
  task automatic t_except();
    logic [7:0] fc[4] = '{8'h00, 8'h05, 8'h83, 8'hFF};
    foreach (fc[i])
      xact({8'h01, fc[i], 32'h00000001}, 6,
           {8'h01, fc[i] | 8'h80, 8'h01}, 3);
    xact(96'h0103F0000001, 6, 96'h018302, 3);
    xact(96'h010300100000, 6, 96'h018303, 3);
    xact(96'h0106F0000001, 6, 96'h018602, 3);
    xact(96'h01100030000202AABB, 9, 96'h019003, 3);
  endtask : t_except
  task automatic t_silent();
    xact(96'h010300100001, 6, 96'h0, 0, 1'b1);
    xact(96'h010300100001, 6, 96'h0, 0, 1'b0, 1'b1);
    xact(96'h020300100001, 6, 96'h0, 0);
    xact(96'h000600400077, 6, 96'h0, 0);
    check("bcast addr", wr_a[$], 16'h0040);
    check("bcast data", wr_d[$], 16'h0077);
    m.raw(bq(96'h0103, 2), 1'b0);
    xact(96'h010300100001, 6, 96'h0103025A10, 5);
  endtask : t_silent
  task automatic t_burst();
    mrs_bq_t e;
    e = bq(96'h010310, 3);
    for (int i = 0; i < 8; i++)
    begin
      e.push_back(8'h5A);
      e.push_back(8'h20 + 8'(i));
    end
    @(posedge clk);
    m.stall <= 1'b1;
    fork
      xq(bq(96'h010300200008, 6), e, 1'b0, 1'b0);
      begin
        repeat (200) @(posedge clk);
        m.stall <= 1'b0;
      end
    join
  endtask : t_burst
  task automatic t_late();
    ack_dly = 100;
    xact(96'h010300100001, 6, 96'h0103025A10, 5);
    check("late cmd", {15'h0000, resp_late}, 16'h0001);
    xact(96'h010340000001, 6, 96'h0103021A00, 5);
    check("late cfg", {15'h0000, resp_late}, 16'h0000);
    ack_dly = 2;
  endtask : t_late
  task automatic t_newid();
    @(posedge clk);
    id_wdata <= 8'h22;
    id_wr <= 1'b1;
    @(posedge clk);
    id_wdata <= 8'h00;
    @(posedge clk);
    id_wr <= 1'b0;
    @(negedge clk);
    check("new id", {8'h00, slave_id}, 16'h0022);
    xact(96'h220300100001, 6, 96'h2203025A10, 5);
    xact(96'h010300100001, 6, 96'h0, 0);
  endtask : t_newid
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    check("tx idle", {15'h0000, tx_valid}, 16'h0000);
    t_normal();
    t_except();
    t_silent();
    t_burst();
    t_late();
    t_newid();
    end_of_test();
  end
endmodule : mrs_frontend_tb_top
